/* adc_cfg_pkg.sv */
package adc_cfg_pkg;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0] addr_speed_grade_id = 8'h02;
    localparam logic [7:0] addr_channel_select = 8'h05;
    localparam logic [7:0] addr_power_mode_control = 8'h08;
    localparam logic [7:0] addr_clock_conditioning = 8'h09;
    localparam logic [7:0] addr_lock_indicator = 8'h0a;
    localparam logic [7:0] addr_sample_clock_divider = 8'h0b;
    localparam logic [7:0] addr_shadow_update = 8'hff;
    localparam logic [7:0] shadow_first = 8'h08;
    localparam logic [7:0] shadow_last = 8'h79;
    localparam logic [7:0] transfer_cmd = 8'h01;

    // ****************************************
    // field positions
    // ****************************************
    localparam int speed_grade_lsb = 4;
    localparam int pin_function_bit = 5;
    localparam int power_mode_lsb = 0;
    localparam int duty_cycle_correction_bit = 0;
    localparam int lock_bit = 7;
    localparam int div_phase_lsb = 3;
    localparam int div_ratio_lsb = 0;
    localparam int transfer_bit = 0;
    localparam int num_channels = 2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [1:0] channel_select_rst = 2'h3;
    localparam logic [2:0] div_code_rst = 3'h0;
    localparam logic duty_cycle_correction_rst = 1'b1;
    localparam logic [7:0] unmapped_read = 8'h00;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        pwr_normal = 2'b00,
        pwr_full_down = 2'b01,
        pwr_standby = 2'b10,
        pwr_reserved = 2'b11
    } power_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfg_req_type;

    typedef struct packed {
        logic pin_standby;
        power_state_type mode;
    } power_cfg_type;

    typedef struct packed {
        logic duty_cycle_correction;
        logic [2:0] phase;
        logic [2:0] ratio;
    } clock_cfg_type;

    localparam power_cfg_type power_cfg_rst = '{pin_standby: 1'b0, mode: pwr_normal};
    localparam clock_cfg_type clock_cfg_rst = '{duty_cycle_correction: duty_cycle_correction_rst,
                                               phase: div_code_rst, ratio: div_code_rst};

endpackage

/* sample_clock_divider_unit.sv */
`timescale 1ns/100ps
`default_nettype none

module sample_clock_divider_unit
    import adc_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [2:0] ratio,
    input wire logic [2:0] phase,
    output logic sample_en_ff
);

    logic [2:0] count_ff;
    logic [2:0] nxt_count;
    logic [7:0] delay_ff;
    logic [7:0] nxt_delay;
    logic nxt_sample_en;

    // ****************************************
    // divide and phase delay
    // ****************************************
    always_comb begin
        if (count_ff >= ratio) begin
            nxt_count = 3'h0;
        end else begin
            nxt_count = count_ff + 3'h1;
        end
        nxt_delay = {delay_ff[6:0], (count_ff == 3'h0)};
        nxt_sample_en = nxt_delay[phase];
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_ff <= 3'h0;
            delay_ff <= 8'h00;
            sample_en_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            delay_ff <= nxt_delay;
            sample_en_ff <= nxt_sample_en;
        end
    end

endmodule

`default_nettype wire

/* adc_config_clock_registers.sv */
`timescale 1ns/100ps
`default_nettype none

module adc_config_clock_registers
    import adc_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire cfg_req_type cfg_req,
    output logic [7:0] rdata_ff,
    input wire logic [1:0] speed_grade_strap,
    input wire logic pll_locked,
    input wire logic power_down_pin,
    output power_state_type power_state_a_ff,
    output power_state_type power_state_b_ff,
    output logic duty_cycle_correction_on_ff,
    output logic sample_en
);

    // ****************************************
    // helpers
    // ****************************************
    // pin asserted picks full down or standby
    function automatic power_state_type eff_power(input logic pin, input power_cfg_type cfg);
        power_state_type res;
        if (pin) begin
            res = cfg.pin_standby ? pwr_standby : pwr_full_down;
        end else if (cfg.mode == pwr_reserved) begin
            res = pwr_normal;
        end else begin
            res = cfg.mode;
        end
        return res;
    endfunction

    function automatic logic [7:0] pack_power(input power_cfg_type cfg);
        logic [7:0] res;
        res = 8'h00;
        res[pin_function_bit] = cfg.pin_standby;
        res[power_mode_lsb +: 2] = cfg.mode;
        return res;
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [1:0] speed_grade_ff;
    logic [1:0] channel_select_ff;
    logic [1:0] nxt_channel_select;
    logic transfer_ff;
    logic nxt_transfer;
    power_cfg_type power_shadow_ff [num_channels];
    power_cfg_type nxt_power_shadow [num_channels];
    power_cfg_type power_active_ff [num_channels];
    power_cfg_type nxt_power_active [num_channels];
    clock_cfg_type clock_shadow_ff;
    clock_cfg_type nxt_clock_shadow;
    clock_cfg_type clock_active_ff;
    clock_cfg_type nxt_clock_active;
    logic [7:0] nxt_rdata;
    power_state_type nxt_power_state_a;
    power_state_type nxt_power_state_b;
    logic nxt_duty_cycle_correction_on;
    power_cfg_type read_power;

    // ****************************************
    // register writes and transfer
    // ****************************************
    always_comb begin
        nxt_channel_select = channel_select_ff;
        nxt_clock_shadow = clock_shadow_ff;
        nxt_clock_active = clock_active_ff;
        nxt_transfer = 1'b0;
        for (int i = 0; i < num_channels; i++) begin
            nxt_power_shadow[i] = power_shadow_ff[i];
            nxt_power_active[i] = power_active_ff[i];
        end
        // commit all shadows together, transfer clears itself
        if (transfer_ff) begin
            nxt_clock_active = clock_shadow_ff;
            for (int i = 0; i < num_channels; i++) begin
                nxt_power_active[i] = power_shadow_ff[i];
            end
        end
        if (cfg_req.wr) begin
            case (cfg_req.addr)
                addr_channel_select: begin
                    nxt_channel_select = cfg_req.wdata[1:0];
                end
                addr_shadow_update: begin
                    // only the command value starts a transfer
                    nxt_transfer = (cfg_req.wdata == transfer_cmd);
                end
                addr_power_mode_control: begin
                    // every selected channel takes the write
                    for (int i = 0; i < num_channels; i++) begin
                        if (channel_select_ff[i]) begin
                            nxt_power_shadow[i].pin_standby = cfg_req.wdata[pin_function_bit];
                            nxt_power_shadow[i].mode = power_state_type'(cfg_req.wdata[power_mode_lsb +: 2]);
                        end
                    end
                end
                addr_clock_conditioning: begin
                    nxt_clock_shadow.duty_cycle_correction = cfg_req.wdata[duty_cycle_correction_bit];
                end
                addr_sample_clock_divider: begin
                    nxt_clock_shadow.phase = cfg_req.wdata[div_phase_lsb +: 3];
                    nxt_clock_shadow.ratio = cfg_req.wdata[div_ratio_lsb +: 3];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // register reads
    // ****************************************
    always_comb begin
        // channel A wins when both are selected
        read_power = channel_select_ff[0] ? power_shadow_ff[0] : power_shadow_ff[1];
        nxt_rdata = rdata_ff;
        if (cfg_req.rd) begin
            nxt_rdata = unmapped_read;
            case (cfg_req.addr)
                addr_speed_grade_id: begin
                    nxt_rdata[speed_grade_lsb +: 2] = speed_grade_ff;
                end
                addr_channel_select: begin
                    nxt_rdata[1:0] = channel_select_ff;
                end
                addr_power_mode_control: begin
                    nxt_rdata = pack_power(read_power);
                end
                addr_clock_conditioning: begin
                    nxt_rdata[duty_cycle_correction_bit] = clock_shadow_ff.duty_cycle_correction;
                end
                addr_lock_indicator: begin
                    nxt_rdata[lock_bit] = pll_locked;
                end
                addr_sample_clock_divider: begin
                    nxt_rdata[div_phase_lsb +: 3] = clock_shadow_ff.phase;
                    nxt_rdata[div_ratio_lsb +: 3] = clock_shadow_ff.ratio;
                end
                addr_shadow_update: begin
                    nxt_rdata[transfer_bit] = transfer_ff;
                end
                default: begin
                    nxt_rdata = unmapped_read;
                end
            endcase
        end
    end

    // ****************************************
    // operating outputs
    // ****************************************
    always_comb begin
        nxt_power_state_a = eff_power(power_down_pin, power_active_ff[0]);
        nxt_power_state_b = eff_power(power_down_pin, power_active_ff[1]);
        nxt_duty_cycle_correction_on = clock_active_ff.duty_cycle_correction ||
                                       (clock_active_ff.ratio != div_code_rst);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            speed_grade_ff <= 2'h0;
            channel_select_ff <= channel_select_rst;
            transfer_ff <= 1'b0;
            clock_shadow_ff <= clock_cfg_rst;
            clock_active_ff <= clock_cfg_rst;
            for (int i = 0; i < num_channels; i++) begin
                power_shadow_ff[i] <= power_cfg_rst;
                power_active_ff[i] <= power_cfg_rst;
            end
            rdata_ff <= 8'h00;
            power_state_a_ff <= pwr_normal;
            power_state_b_ff <= pwr_normal;
            duty_cycle_correction_on_ff <= duty_cycle_correction_rst;
        end else begin
            speed_grade_ff <= speed_grade_strap;
            channel_select_ff <= nxt_channel_select;
            transfer_ff <= nxt_transfer;
            clock_shadow_ff <= nxt_clock_shadow;
            clock_active_ff <= nxt_clock_active;
            for (int i = 0; i < num_channels; i++) begin
                power_shadow_ff[i] <= nxt_power_shadow[i];
                power_active_ff[i] <= nxt_power_active[i];
            end
            rdata_ff <= nxt_rdata;
            power_state_a_ff <= nxt_power_state_a;
            power_state_b_ff <= nxt_power_state_b;
            duty_cycle_correction_on_ff <= nxt_duty_cycle_correction_on;
        end
    end

    // ****************************************
    // sample clock divider
    // ****************************************
    // committed ratio drives the divider
    // committed phase drives the delay tap
    sample_clock_divider_unit u_divider (
        .clk(clk),
        .reset_n(reset_n),
        .ratio(clock_active_ff.ratio),
        .phase(clock_active_ff.phase),
        .sample_en_ff(sample_en)
    );

endmodule

`default_nettype wire

/* adc_cfg_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module adc_cfg_sva
    import adc_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire cfg_req_type cfg_req,
    input wire logic [7:0] rdata_ff,
    input wire logic [1:0] speed_grade_strap,
    input wire logic pll_locked,
    input wire logic power_down_pin,
    input wire power_state_type power_state_a_ff,
    input wire power_state_type power_state_b_ff,
    input wire logic duty_cycle_correction_on_ff,
    input wire logic sample_en
);
    // ********
    // expected shadow and live copies
    // ********
    logic [1:0] sel_ff, nxt_sel;
    logic [2:0] sa_ff, sb_ff, aa_ff, ab_ff, nxt_sa, nxt_sb, nxt_aa, nxt_ab;
    logic [5:0] sd_ff, ad_ff, nxt_sd, nxt_ad;
    wire logic wr = cfg_req.wr;
    wire logic w08 = wr && cfg_req.addr == addr_power_mode_control;
    wire logic xfer = wr && cfg_req.addr == addr_shadow_update && cfg_req.wdata == transfer_cmd;
    wire logic [2:0] wpm = {cfg_req.wdata[pin_function_bit], cfg_req.wdata[1:0]};
    assign nxt_sel = (wr && cfg_req.addr == addr_channel_select) ? cfg_req.wdata[1:0] : sel_ff;
    assign nxt_sa = (w08 && sel_ff[0]) ? wpm : sa_ff;
    assign nxt_sb = (w08 && sel_ff[1]) ? wpm : sb_ff;
    assign nxt_sd = (wr && cfg_req.addr == addr_sample_clock_divider) ? cfg_req.wdata[5:0] : sd_ff;
    assign nxt_aa = xfer ? sa_ff : aa_ff;
    assign nxt_ab = xfer ? sb_ff : ab_ff;
    assign nxt_ad = xfer ? sd_ff : ad_ff;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {sel_ff, sa_ff, sb_ff, aa_ff, ab_ff, sd_ff, ad_ff} <= {2'h3, 24'h00_0000};
        end else begin
            {sel_ff, sa_ff, sb_ff, aa_ff, ab_ff, sd_ff, ad_ff} <=
                {nxt_sel, nxt_sa, nxt_sb, nxt_aa, nxt_ab, nxt_sd, nxt_ad};
        end
    end
    // ********
    // checks
    // ********
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_pin_function: assert property (
        (power_down_pin && $stable(aa_ff))[*6] |-> power_state_a_ff == (aa_ff[2] ? pwr_standby : pwr_full_down))
        else $error("pin power state wrong");
    a_mode_a: assert property (
        (!power_down_pin && $stable(aa_ff))[*6] |-> power_state_a_ff == ((aa_ff[1:0] == 2'h3) ? 2'h0 : aa_ff[1:0]))
        else $error("channel a power state wrong");
    a_mode_b: assert property (
        (!power_down_pin && $stable(ab_ff))[*6] |-> power_state_b_ff == ((ab_ff[1:0] == 2'h3) ? 2'h0 : ab_ff[1:0]))
        else $error("channel b power state wrong");
    a_div_one: assert property (
        $stable(ad_ff)[*8] ##1 $stable(ad_ff)[*4] ##0 (ad_ff[2:0] == 3'h0) |-> sample_en)
        else $error("undivided pulse missing");
    a_div_three: assert property (
        $stable(ad_ff)[*8] ##1 $stable(ad_ff)[*4] ##0 (ad_ff[2:0] == 3'h2 && sample_en)
        |=> !sample_en ##1 !sample_en ##1 sample_en)
        else $error("divide by three period wrong");
    a_forced_dcc: assert property (
        (ad_ff[2:0] != 3'h0)[*6] |-> duty_cycle_correction_on_ff)
        else $error("stabilizer not forced");
    a_shadow_hold: assert property (
        (!xfer)[*6] |-> $stable(duty_cycle_correction_on_ff))
        else $error("stabilizer moved without transfer");
    a_read_select: assert property (
        cfg_req.rd && cfg_req.addr == addr_channel_select |=> rdata_ff[1:0] == $past(sel_ff))
        else $error("channel select readback wrong");
    a_both_read: assert property (
        cfg_req.rd && !wr && cfg_req.addr == addr_power_mode_control && sel_ff == 2'h3
        |=> rdata_ff == {2'h0, sa_ff[2], 3'h0, sa_ff[1:0]})
        else $error("dual select read not channel a");
endmodule
bind adc_config_clock_registers adc_cfg_sva chk (.clk(clk), .reset_n(reset_n), .cfg_req(cfg_req),
    .rdata_ff(rdata_ff), .speed_grade_strap(speed_grade_strap), .pll_locked(pll_locked),
    .power_down_pin(power_down_pin), .power_state_a_ff(power_state_a_ff),
    .power_state_b_ff(power_state_b_ff), .duty_cycle_correction_on_ff(duty_cycle_correction_on_ff),
    .sample_en(sample_en));
`default_nettype wire

/* cfg_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cfg_host_model
    import adc_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] rdata_ff,
    output cfg_req_type cfg_req
);
    initial cfg_req = '0;
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cfg_req <= '{wr: 1'h1, rd: 1'h0, addr: a, wdata: d};
        @(posedge clk);
        cfg_req <= '0;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        cfg_req <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
        @(posedge clk);
        cfg_req <= '0;
        #1 d = rdata_ff;
    endtask
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import adc_cfg_pkg::*;
;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic pin = 1'h0;
    logic lock = 1'h1;
    logic [1:0] grade = 2'h2;
    cfg_req_type req;
    logic [7:0] rdata, got;
    power_state_type st_a, st_b;
    logic dcc, sen;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int t1, t2;
    always #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    adc_config_clock_registers dut (.clk(clk), .reset_n(reset_n), .cfg_req(req), .rdata_ff(rdata),
        .speed_grade_strap(grade), .pll_locked(lock), .power_down_pin(pin), .power_state_a_ff(st_a),
        .power_state_b_ff(st_b), .duty_cycle_correction_on_ff(dcc), .sample_en(sen));
    cfg_host_model host (.clk(clk), .rdata_ff(rdata), .cfg_req(req));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        host.get(a, got);
        chk(got, e);
    endtask
    task automatic commit();
        host.put(addr_shadow_update, transfer_cmd);
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic pulse(output int t);
        int n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (sen !== 1'h1 && n < 20);
        t = cyc;
    endtask
    task automatic t_reset();
        rd(8'h05, 8'h03);
        rd(8'h08, 8'h00);
        rd(8'h09, 8'h01);
        rd(8'h0a, 8'h80);
        rd(8'h0b, 8'h00);
        rd(8'hff, 8'h00);
        host.put(8'h02, 8'hff);
        host.put(8'h0a, 8'h00);
        rd(8'h02, 8'h20);
        rd(8'h0a, 8'h80);
        rd(8'h03, 8'h00);
        @(posedge clk) begin
            grade <= 2'h1;
            lock <= 1'h0;
        end
        rd(8'h02, 8'h10);
        rd(8'h0a, 8'h00);
    endtask
    task automatic t_divider();
        host.put(addr_sample_clock_divider, 8'h02);
        host.put(addr_clock_conditioning, 8'h00);
        rd(addr_sample_clock_divider, 8'h02);
        pulse(t1);
        pulse(t2);
        chk(8'(t2 - t1), 8'h01);
        commit();
        rd(addr_shadow_update, 8'h00);
        chk({7'h0, dcc}, 8'h01);
        pulse(t1);
        pulse(t2);
        chk(8'(t2 - t1), 8'h03);
        host.put(addr_sample_clock_divider, 8'h07);
        commit();
        chk({7'h0, dcc}, 8'h01);
        pulse(t1);
        host.put(addr_sample_clock_divider, 8'h1f);
        commit();
        pulse(t2);
        pulse(t2);
        chk(8'((t2 - t1) % 8), 8'h03);
        host.put(addr_sample_clock_divider, 8'h00);
        commit();
        chk({7'h0, dcc}, 8'h00);
        host.put(addr_clock_conditioning, 8'h01);
        commit();
        chk({7'h0, dcc}, 8'h01);
    endtask
    task automatic t_power();
        host.put(addr_channel_select, 8'h01);
        host.put(addr_power_mode_control, 8'h20);
        host.put(addr_channel_select, 8'h02);
        host.put(addr_power_mode_control, 8'h01);
        rd(addr_power_mode_control, 8'h01);
        host.put(addr_channel_select, 8'h03);
        rd(addr_power_mode_control, 8'h20);
        chk({4'h0, st_a, st_b}, 8'h00);
        commit();
        chk({4'h0, st_a, st_b}, 8'h01);
        @(posedge clk) pin <= 1'h1;
        repeat (3) @(posedge clk);
        #1 chk({4'h0, st_a, st_b}, 8'h09);
        host.put(addr_power_mode_control, 8'h02);
        commit();
        chk({4'h0, st_a, st_b}, 8'h05);
        @(posedge clk) pin <= 1'h0;
        repeat (3) @(posedge clk);
        #1 chk({4'h0, st_a, st_b}, 8'h0a);
        host.put(addr_power_mode_control, 8'h03);
        commit();
        chk({4'h0, st_a, st_b}, 8'h00);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'h1;
        t_reset();
        t_divider();
        t_power();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end
endmodule
`default_nettype wire
